// file: include/attitude_error_pkg.sv
package attitude_error_pkg;
  localparam int ANG_W = 16;
  localparam int ADDR_W = 5;
  localparam int NUM_AXES = 3;
  localparam int Q_FRAC = 14;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CYCLE_TIME_MS = 100;
  localparam int CYCLE_CLKS = CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int REFRESH_TIME_MS = 1000;
  localparam int REFRESH_TICKS = REFRESH_TIME_MS / CYCLE_TIME_MS;
  localparam int CYCLES_PER_SEC = 1000 / CYCLE_TIME_MS;
  localparam int OFFSET_CDEG = 725; // hundredths of a degree
  localparam int CIRCLE_CDEG = 36000;
  localparam logic [ANG_W-1:0] OUTER_OFFSET =
    ANG_W'((OFFSET_CDEG * (1 << ANG_W) + CIRCLE_CDEG / 2) / CIRCLE_CDEG);
  localparam logic [ANG_W-1:0] QUARTER_TURN = 16'h4000;
  localparam logic [ANG_W-1:0] COEF_ONE = 16'h4000;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_SNAP = 5'h01;
  localparam logic [ADDR_W-1:0] ADDR_REF = 5'h02;
  localparam logic [ADDR_W-1:0] ADDR_BIAS = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_SAVED = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_PLUSX = 5'h0e;
  localparam logic [ADDR_W-1:0] ADDR_RATE = 5'h11;
  localparam logic [ADDR_W-1:0] ADDR_ERR = 5'h12;
  localparam logic [ADDR_W-1:0] ADDR_NEEDLE = 5'h15;
  localparam int CTRL_REF_LSB = 0;
  localparam int CTRL_REF_W = 3;
  localparam int CTRL_DISP_LSB = 3;
  localparam int CTRL_MANUAL_BIT = 5;
  localparam int CTRL_DAMP_BIT = 6;
  typedef enum logic [2:0] {
    REF_SAMPLE = 3'h1,
    REF_HOLD = 3'h2,
    REF_AUTO = 3'h4
  } ref_state_e;
  localparam logic [1:0] DISP_OFF = 2'h0;
  localparam logic [1:0] DISP_ERR = 2'h1;
  localparam logic [1:0] DISP_CMD = 2'h2;
  localparam logic [1:0] HC_POS = 2'h1;
  localparam logic [1:0] HC_NEG = 2'h3;
  // quarter-wave sine in Q14, 5.6 degree steps: coarse but cheap
  localparam logic [ANG_W-1:0] SIN_TAB [17] = '{
    16'h0000, 16'h0646, 16'h0c7c, 16'h1294, 16'h187e, 16'h1e2b,
    16'h238e, 16'h289a, 16'h2d41, 16'h3179, 16'h3537, 16'h3871,
    16'h3b21, 16'h3d3f, 16'h3ec5, 16'h3fb1, 16'h4000};

  function automatic logic signed [ANG_W-1:0] sin_q(input logic [ANG_W-1:0] a);
    logic [4:0] k;
    logic signed [ANG_W-1:0] m;
    k = a[ANG_W-2] ? 5'h10 - {1'b0, a[ANG_W-3 -: 4]} : {1'b0, a[ANG_W-3 -: 4]};
    m = SIN_TAB[k];
    return a[ANG_W-1] ? -m : m;
  endfunction

  function automatic logic signed [ANG_W-1:0] mulq(input logic signed [ANG_W-1:0] x,
                                                   input logic signed [ANG_W-1:0] c);
    logic signed [2*ANG_W-1:0] p;
    p = x * c;
    return p[Q_FRAC +: ANG_W];
  endfunction
endpackage

// file: rtl/attitude_error_display.sv
`timescale 1ns/1ps
`default_nettype none
module attitude_error_display #(
  parameter int CYCLE_CLKS = attitude_error_pkg::CYCLE_CLKS,
  parameter int REFRESH_TICKS = attitude_error_pkg::REFRESH_TICKS
) (
  input wire logic clk_i, // 125 MHz
  input wire logic rst_i, // sync, active high
  input wire logic [4:0] addr_i, // register index
  input wire logic [15:0] wr_data_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [15:0] rd_data_o, // read data, cycle after rd_i
  input wire logic [15:0] outer_angle_i, // outer gimbal readout
  input wire logic [15:0] inner_angle_i, // inner gimbal readout
  input wire logic [15:0] middle_angle_i, // middle gimbal readout
  input wire logic [5:0] rotation_hand_controller_i, // 2 bits per axis
  output logic [15:0] needle_roll_o, // roll needle
  output logic [15:0] needle_pitch_o, // pitch needle
  output logic [15:0] needle_yaw_o, // yaw needle
  output logic [2:0] control_reference_state_o // current reference state
);
  localparam int W = attitude_error_pkg::ANG_W;
  localparam int AW = attitude_error_pkg::ADDR_W;
  localparam int N = attitude_error_pkg::NUM_AXES;
  typedef logic signed [W-1:0] ang_t;

  function automatic logic in_group(input logic [AW-1:0] a, input logic [AW-1:0] base);
    return (a >= base) && (a < AW'(base + AW'(N)));
  endfunction

  function automatic logic [1:0] grp_idx(input logic [AW-1:0] a, input logic [AW-1:0] base);
    logic [AW-1:0] d;
    d = a - base;
    return d[1:0];
  endfunction

  // gimbal words are synchronised bitwise; a readout must hold
  // steady for two clocks or one sample may be torn
  ang_t gim_m_q [N];
  ang_t gim_q [N];
  logic [5:0] hc_m_q;
  logic [5:0] hc_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        gim_m_q[i] <= '0;
        gim_q[i] <= '0;
      end
      hc_m_q <= '0;
      hc_q <= '0;
    end else begin
      gim_m_q[0] <= outer_angle_i;
      gim_m_q[1] <= inner_angle_i;
      gim_m_q[2] <= middle_angle_i;
      gim_q <= gim_m_q;
      hc_m_q <= rotation_hand_controller_i;
      hc_q <= hc_m_q;
    end
  end

  logic [31:0] div_q;
  logic tick;
  assign tick = div_q == 32'(CYCLE_CLKS - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  logic [7:0] refr_q;
  logic refresh;
  assign refresh = tick && (refr_q == '0);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refr_q <= '0;
    end else if (tick) begin
      refr_q <= (refr_q == 8'(REFRESH_TICKS - 1)) ? '0 : refr_q + 8'h01;
    end
  end

  attitude_error_pkg::ref_state_e state_q;
  logic [1:0] disp_q;
  logic manual_q;
  logic damp_q;
  logic [W-1:0] rate_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= attitude_error_pkg::REF_HOLD;
      disp_q <= attitude_error_pkg::DISP_ERR;
      manual_q <= 1'b0;
      damp_q <= 1'b0;
      rate_q <= '0;
    end else begin
      if (wr_i && addr_i == attitude_error_pkg::ADDR_CTRL) begin
        unique case (wr_data_i[attitude_error_pkg::CTRL_REF_LSB +: attitude_error_pkg::CTRL_REF_W])
          attitude_error_pkg::REF_SAMPLE,
          attitude_error_pkg::REF_HOLD,
          attitude_error_pkg::REF_AUTO: begin
            state_q <= attitude_error_pkg::ref_state_e'(
              wr_data_i[attitude_error_pkg::CTRL_REF_LSB +: attitude_error_pkg::CTRL_REF_W]);
          end
          default: begin
            state_q <= state_q; // illegal codes leave the state alone
          end
        endcase
        disp_q <= wr_data_i[attitude_error_pkg::CTRL_DISP_LSB +: 2];
        manual_q <= wr_data_i[attitude_error_pkg::CTRL_MANUAL_BIT];
        damp_q <= wr_data_i[attitude_error_pkg::CTRL_DAMP_BIT];
      end else if (tick && state_q == attitude_error_pkg::REF_SAMPLE) begin
        state_q <= attitude_error_pkg::REF_HOLD;
      end
      if (wr_i && addr_i == attitude_error_pkg::ADDR_RATE) begin
        rate_q <= wr_data_i;
      end
    end
  end

  ang_t ref_q [N];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        ref_q[i] <= '0;
      end
    end else if (tick && state_q == attitude_error_pkg::REF_SAMPLE) begin
      ref_q <= gim_q;
    end else if (wr_i && in_group(addr_i, attitude_error_pkg::ADDR_REF)) begin
      ref_q[grp_idx(addr_i, attitude_error_pkg::ADDR_REF)] <= wr_data_i;
    end
  end

  ang_t bias_q [N];
  ang_t cmd_q [N];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        bias_q[i] <= '0;
        cmd_q[i] <= '0;
      end
    end else if (wr_i) begin
      if (in_group(addr_i, attitude_error_pkg::ADDR_BIAS)) begin
        bias_q[grp_idx(addr_i, attitude_error_pkg::ADDR_BIAS)] <= wr_data_i;
      end
      if (in_group(addr_i, attitude_error_pkg::ADDR_CMD)) begin
        cmd_q[grp_idx(addr_i, attitude_error_pkg::ADDR_CMD)] <= wr_data_i;
      end
    end
  end

  // one store answers to both the saved and the plus-x names,
  // so a write through either one clobbers the other
  ang_t saved_q [N];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        saved_q[i] <= '0;
      end
    end else if (wr_i && addr_i == attitude_error_pkg::ADDR_SNAP) begin
      saved_q <= gim_q;
    end else if (wr_i && in_group(addr_i, attitude_error_pkg::ADDR_SAVED)) begin
      saved_q[grp_idx(addr_i, attitude_error_pkg::ADDR_SAVED)] <= wr_data_i;
    end else if (wr_i && in_group(addr_i, attitude_error_pkg::ADDR_PLUSX)) begin
      saved_q[grp_idx(addr_i, attitude_error_pkg::ADDR_PLUSX)] <= wr_data_i;
    end
  end

  ang_t off_outer;
  ang_t sin_mid;
  ang_t cos_mid;
  ang_t sin_off;
  ang_t cos_off;
  always_comb begin
    off_outer = gim_q[0] - attitude_error_pkg::OUTER_OFFSET;
    sin_mid = attitude_error_pkg::sin_q(gim_q[2]);
    cos_mid = attitude_error_pkg::sin_q(W'(gim_q[2] + attitude_error_pkg::QUARTER_TURN));
    sin_off = attitude_error_pkg::sin_q(off_outer);
    cos_off = attitude_error_pkg::sin_q(W'(off_outer + attitude_error_pkg::QUARTER_TURN));
  end

  // trig is only refreshed once a second; small-angle errors tolerate it
  ang_t k_sm_q;
  ang_t k_cc_q;
  ang_t k_so_q;
  ang_t k_cs_q;
  ang_t k_co_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      k_sm_q <= '0;
      k_cc_q <= attitude_error_pkg::COEF_ONE;
      k_so_q <= '0;
      k_cs_q <= '0;
      k_co_q <= attitude_error_pkg::COEF_ONE;
    end else if (refresh) begin
      k_sm_q <= sin_mid;
      k_cc_q <= attitude_error_pkg::mulq(cos_mid, cos_off);
      k_so_q <= sin_off;
      k_cs_q <= attitude_error_pkg::mulq(cos_mid, sin_off);
      k_co_q <= cos_off;
    end
  end

  ang_t prev_q [N];
  ang_t ctl_in [N];
  ang_t ctl_out [N];
  ang_t dsp_in [N];
  ang_t dsp_out [N];
  ang_t inc [N];
  ang_t step;
  always_comb begin
    step = W'(rate_q / attitude_error_pkg::CYCLES_PER_SEC);
    for (int i = 0; i < N; i++) begin
      if (manual_q) begin
        ctl_in[i] = gim_q[i] - prev_q[i];
      end else begin
        ctl_in[i] = gim_q[i] - ref_q[i];
      end
      if (disp_q == attitude_error_pkg::DISP_CMD) begin
        dsp_in[i] = cmd_q[i] - gim_q[i];
      end else begin
        dsp_in[i] = saved_q[i] - gim_q[i];
      end
      if (hc_q[2*i +: 2] == attitude_error_pkg::HC_POS) begin
        inc[i] = step;
      end else if (hc_q[2*i +: 2] == attitude_error_pkg::HC_NEG) begin
        inc[i] = -step;
      end else begin
        inc[i] = '0;
      end
    end
  end

  axis_resolver #(.W(W)) u_ctl_res (
    .d_outer_i(ctl_in[0]),
    .d_inner_i(ctl_in[1]),
    .d_middle_i(ctl_in[2]),
    .k_sm_i(k_sm_q),
    .k_cc_i(k_cc_q),
    .k_so_i(k_so_q),
    .k_cs_i(k_cs_q),
    .k_co_i(k_co_q),
    .roll_o(ctl_out[0]),
    .pitch_o(ctl_out[1]),
    .yaw_o(ctl_out[2])
  );

  axis_resolver #(.W(W)) u_dsp_res (
    .d_outer_i(dsp_in[0]),
    .d_inner_i(dsp_in[1]),
    .d_middle_i(dsp_in[2]),
    .k_sm_i(k_sm_q),
    .k_cc_i(k_cc_q),
    .k_so_i(k_so_q),
    .k_cs_i(k_cs_q),
    .k_co_i(k_co_q),
    .roll_o(dsp_out[0]),
    .pitch_o(dsp_out[1]),
    .yaw_o(dsp_out[2])
  );

  ang_t err_q [N];
  ang_t err_d [N];
  ang_t needle_q [N];
  ang_t needle_d [N];
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (manual_q && damp_q) begin
        err_d[i] = '0;
      end else if (manual_q) begin
        err_d[i] = err_q[i] - inc[i] + ctl_out[i];
      end else if (state_q == attitude_error_pkg::REF_AUTO) begin
        err_d[i] = ctl_out[i] + bias_q[i];
      end else begin
        err_d[i] = ctl_out[i];
      end
      if (disp_q == attitude_error_pkg::DISP_OFF) begin
        needle_d[i] = '0;
      end else if (disp_q == attitude_error_pkg::DISP_ERR) begin
        needle_d[i] = -err_d[i];
      end else begin
        needle_d[i] = dsp_out[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < N; i++) begin
        err_q[i] <= '0;
        prev_q[i] <= '0;
        needle_q[i] <= '0;
      end
    end else if (tick) begin
      err_q <= err_d;
      prev_q <= gim_q;
      needle_q <= needle_d;
    end
  end

  logic [15:0] rd_word;
  logic [15:0] rd_data_q;
  always_comb begin
    rd_word = '0;
    if (addr_i == attitude_error_pkg::ADDR_CTRL) begin
      rd_word[attitude_error_pkg::CTRL_REF_LSB +: attitude_error_pkg::CTRL_REF_W] = state_q;
      rd_word[attitude_error_pkg::CTRL_DISP_LSB +: 2] = disp_q;
      rd_word[attitude_error_pkg::CTRL_MANUAL_BIT] = manual_q;
      rd_word[attitude_error_pkg::CTRL_DAMP_BIT] = damp_q;
    end else if (addr_i == attitude_error_pkg::ADDR_RATE) begin
      rd_word = rate_q;
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_REF)) begin
      rd_word = ref_q[grp_idx(addr_i, attitude_error_pkg::ADDR_REF)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_BIAS)) begin
      rd_word = bias_q[grp_idx(addr_i, attitude_error_pkg::ADDR_BIAS)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_CMD)) begin
      rd_word = cmd_q[grp_idx(addr_i, attitude_error_pkg::ADDR_CMD)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_SAVED)) begin
      rd_word = saved_q[grp_idx(addr_i, attitude_error_pkg::ADDR_SAVED)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_PLUSX)) begin
      rd_word = saved_q[grp_idx(addr_i, attitude_error_pkg::ADDR_PLUSX)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_ERR)) begin
      rd_word = err_q[grp_idx(addr_i, attitude_error_pkg::ADDR_ERR)];
    end else if (in_group(addr_i, attitude_error_pkg::ADDR_NEEDLE)) begin
      rd_word = needle_q[grp_idx(addr_i, attitude_error_pkg::ADDR_NEEDLE)];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_i ? rd_word : 16'h0000;
    end
  end

  assign rd_data_o = rd_data_q;
  assign needle_roll_o = needle_q[0];
  assign needle_pitch_o = needle_q[1];
  assign needle_yaw_o = needle_q[2];
  assign control_reference_state_o = state_q;

  property p_needles_still;
    @(posedge clk_i) disable iff (rst_i)
    !tick |=> $stable(needle_q[0]) && $stable(needle_q[1]) && $stable(needle_q[2]);
  endproperty
  a_needles_still: assert property (p_needles_still) else $error("needle moved off tick");

  property p_coef_hold;
    @(posedge clk_i) disable iff (rst_i)
    !refresh |=> $stable(k_sm_q) && $stable(k_co_q) && $stable(k_cc_q);
  endproperty
  a_coef_hold: assert property (p_coef_hold) else $error("coefficient changed off refresh");

  property p_hold_err;
    @(posedge clk_i) disable iff (rst_i)
    tick && !manual_q && state_q == attitude_error_pkg::REF_HOLD
      |=> err_q[0] == $past(ctl_out[0]) && err_q[2] == $past(ctl_out[2]);
  endproperty
  a_hold_err: assert property (p_hold_err) else $error("hold error carries bias");

  property p_auto_err;
    @(posedge clk_i) disable iff (rst_i)
    tick && !manual_q && state_q == attitude_error_pkg::REF_AUTO
      |=> err_q[1] == ang_t'($past(ctl_out[1]) + $past(bias_q[1]));
  endproperty
  a_auto_err: assert property (p_auto_err) else $error("auto error misses bias");

  property p_integrate;
    @(posedge clk_i) disable iff (rst_i)
    tick && manual_q && !damp_q
      |=> err_q[0] == ang_t'($past(err_q[0]) - $past(inc[0]) + $past(ctl_out[0]));
  endproperty
  a_integrate: assert property (p_integrate) else $error("manual error not integrated");

  property p_damp_zero;
    @(posedge clk_i) disable iff (rst_i)
    tick && manual_q && damp_q |=> err_q[2] == '0;
  endproperty
  a_damp_zero: assert property (p_damp_zero) else $error("error not cleared while damping");

  property p_disp_err;
    @(posedge clk_i) disable iff (rst_i)
    tick && disp_q == attitude_error_pkg::DISP_ERR |=> needle_q[1] == ang_t'(-err_q[1]);
  endproperty
  a_disp_err: assert property (p_disp_err) else $error("mode 1 needle not negated error");

  property p_snapshot;
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == attitude_error_pkg::ADDR_SNAP |=> saved_q[1] == $past(gim_q[1]);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("snapshot not stored");

  property p_alias;
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == attitude_error_pkg::ADDR_PLUSX |=> saved_q[0] == $past(wr_data_i);
  endproperty
  a_alias: assert property (p_alias) else $error("plus-x write missed saved store");

  property p_sample;
    @(posedge clk_i) disable iff (rst_i)
    tick && state_q == attitude_error_pkg::REF_SAMPLE && !wr_i
      |=> state_q == attitude_error_pkg::REF_HOLD && ref_q[2] == $past(gim_q[2]);
  endproperty
  a_sample: assert property (p_sample) else $error("sample state did not capture");
endmodule // attitude_error_display
`default_nettype wire

// file: rtl/axis_resolver.sv
`timescale 1ns/1ps
`default_nettype none
module axis_resolver #(
  parameter int W = attitude_error_pkg::ANG_W
) (
  input wire logic signed [W-1:0] d_outer_i, // outer gimbal term
  input wire logic signed [W-1:0] d_inner_i, // inner gimbal term
  input wire logic signed [W-1:0] d_middle_i, // middle gimbal term
  input wire logic signed [W-1:0] k_sm_i, // sin middle
  input wire logic signed [W-1:0] k_cc_i, // cos middle cos off
  input wire logic signed [W-1:0] k_so_i, // sin off
  input wire logic signed [W-1:0] k_cs_i, // cos middle sin off
  input wire logic signed [W-1:0] k_co_i, // cos off
  output logic signed [W-1:0] roll_o, // roll axis
  output logic signed [W-1:0] pitch_o, // pitch axis
  output logic signed [W-1:0] yaw_o // yaw axis
);
  // results wrap modulo a full turn, like the angles themselves
  assign roll_o = d_outer_i + attitude_error_pkg::mulq(d_inner_i, k_sm_i);
  assign pitch_o = attitude_error_pkg::mulq(d_inner_i, k_cc_i)
                 + attitude_error_pkg::mulq(d_middle_i, k_so_i);
  assign yaw_o = attitude_error_pkg::mulq(d_middle_i, k_co_i)
               - attitude_error_pkg::mulq(d_inner_i, k_cs_i);
endmodule // axis_resolver
`default_nettype wire

// file: tb/gimbal_partner.sv
`timescale 1ns/1ps
`default_nettype none
module gimbal_partner (
  input wire logic clk_i, // bench clock
  output logic [15:0] outer_o, // outer gimbal readout
  output logic [15:0] inner_o, // inner gimbal readout
  output logic [15:0] middle_o, // middle gimbal readout
  output logic [5:0] hc_o // hand controller position
);
  initial begin
    outer_o = 16'h0000;
    inner_o = 16'h0000;
    middle_o = 16'h0000;
    hc_o = 6'h00;
  end

  // readouts move just after an edge and then hold until the next command
  task automatic set(input logic [15:0] o, input logic [15:0] i, input logic [15:0] m, input logic [5:0] h);
    @(posedge clk_i);
    outer_o <= o;
    inner_o <= i;
    middle_o <= m;
    hc_o <= h;
  endtask
endmodule // gimbal_partner
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int CYC = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rd_data_o, outer, inner, middle, n_roll, n_pitch, n_yaw;
  logic [5:0] hc;
  logic [2:0] state;
  logic [15:0] e1 [3];
  int n_fail = 0;
  int n_checks = 0;

  initial forever #4 clk_i = ~clk_i;

  gimbal_partner i_part (.clk_i(clk_i), .outer_o(outer), .inner_o(inner), .middle_o(middle), .hc_o(hc));

  attitude_error_display #(.CYCLE_CLKS(CYC), .REFRESH_TICKS(3)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .outer_angle_i(outer), .inner_angle_i(inner), .middle_angle_i(middle),
    .rotation_hand_controller_i(hc), .needle_roll_o(n_roll), .needle_pitch_o(n_pitch),
    .needle_yaw_o(n_yaw), .control_reference_state_o(state));

  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] x);
    logic [15:0] d;
    rd(a, d);
    chk(d, x);
  endtask

  // read pattern must match the one used for e1 so tick spacing stays exact
  task automatic errs(input logic [15:0] r, input logic [15:0] p, input logic [15:0] y);
    logic [15:0] d [3];
    for (int k = 0; k < 3; k++) rd(attitude_error_pkg::ADDR_ERR + 5'(k), d[k]);
    chk(d[0], r);
    chk(d[1], p);
    chk(d[2], y);
  endtask

  task automatic ndl(input logic [15:0] r, input logic [15:0] p, input logic [15:0] y);
    chk(n_roll, r);
    chk(n_pitch, p);
    chk(n_yaw, y);
  endtask

  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge clk_i);
  endtask

  task automatic t_reset();
    chk({13'h0000, state}, 16'h0002);
    rdc(attitude_error_pkg::ADDR_CTRL, 16'h000a);
    ndl(16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic t_hold();
    // outer at the 7.25 degree offset keeps the offset-angle terms exact
    i_part.set(16'h0528, 16'h0300, 16'h0000, 6'h00);
    wr(attitude_error_pkg::ADDR_REF, 16'h0500);
    wr(attitude_error_pkg::ADDR_REF + 5'h01, 16'h0100);
    wr(attitude_error_pkg::ADDR_REF + 5'h02, 16'h0010);
    ticks(3);
    errs(16'h0028, 16'h0200, 16'hfff0);
    ndl(16'hffd8, 16'hfe00, 16'h0010);
  endtask

  task automatic t_auto();
    for (int k = 0; k < 3; k++) wr(attitude_error_pkg::ADDR_BIAS + 5'(k), 16'(k + 1));
    ticks(2);
    errs(16'h0028, 16'h0200, 16'hfff0);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h000c);
    ticks(2);
    chk({13'h0000, state}, 16'h0004);
    errs(16'h0029, 16'h0202, 16'hfff3);
  endtask

  task automatic t_sample();
    wr(attitude_error_pkg::ADDR_CTRL, 16'h0009);
    ticks(2);
    chk({13'h0000, state}, 16'h0002);
    rdc(attitude_error_pkg::ADDR_REF, 16'h0528);
    rdc(attitude_error_pkg::ADDR_REF + 5'h01, 16'h0300);
    errs(16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic t_manual();
    i_part.set(16'h0528, 16'h0300, 16'h0000, 6'b001101);
    wr(attitude_error_pkg::ADDR_RATE, 16'h0064);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h002a);
    ticks(2);
    for (int k = 0; k < 3; k++) rd(attitude_error_pkg::ADDR_ERR + 5'(k), e1[k]);
    i_part.set(16'h0528, 16'h0340, 16'h0000, 6'b001101);
    // 33 edges plus the read and set overhead put exactly two ticks between samples
    repeat (33) @(posedge clk_i);
    errs(e1[0] - 16'h0014, e1[1] + 16'h0054, e1[2]);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h006a);
    ticks(2);
    errs(16'h0000, 16'h0000, 16'h0000);
    i_part.set(16'h0528, 16'h0300, 16'h0000, 6'h00);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h000a);
  endtask

  task automatic t_display();
    wr(attitude_error_pkg::ADDR_CMD, 16'h0600);
    wr(attitude_error_pkg::ADDR_CMD + 5'h01, 16'h0300);
    wr(attitude_error_pkg::ADDR_CMD + 5'h02, 16'h0020);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h0012);
    ticks(2);
    ndl(16'h00d8, 16'h0000, 16'h0020);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h001a);
    wr(attitude_error_pkg::ADDR_SNAP, 16'h0000);
    ticks(2);
    ndl(16'h0000, 16'h0000, 16'h0000);
    rdc(attitude_error_pkg::ADDR_PLUSX, 16'h0528);
    rdc(attitude_error_pkg::ADDR_PLUSX + 5'h01, 16'h0300);
    // the snapshot has been read back, so clobbering it through plus-x is harmless now
    wr(attitude_error_pkg::ADDR_PLUSX, 16'h0628);
    wr(attitude_error_pkg::ADDR_SAVED + 5'h02, 16'h0008);
    rdc(attitude_error_pkg::ADDR_SAVED, 16'h0628);
    rdc(attitude_error_pkg::ADDR_PLUSX + 5'h02, 16'h0008);
    ticks(2);
    ndl(16'h0100, 16'h0000, 16'h0008);
    wr(attitude_error_pkg::ADDR_CTRL, 16'h0002);
    ticks(2);
    ndl(16'h0000, 16'h0000, 16'h0000);
  endtask

  task automatic t_refuse();
    rdc(5'h1f, 16'h0000);
    wr(attitude_error_pkg::ADDR_ERR, 16'h1234);
    rdc(attitude_error_pkg::ADDR_ERR, 16'h0000);
    // an illegal reference code must leave the state alone
    wr(attitude_error_pkg::ADDR_CTRL, 16'h0003);
    rdc(attitude_error_pkg::ADDR_CTRL, 16'h0002);
    chk({13'h0000, state}, 16'h0002);
    @(posedge clk_i);
    #1 chk(rd_data_o, 16'h0000);
  endtask

  initial begin
    #50000;
    n_fail++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 t_reset();
    t_hold();
    t_auto();
    t_sample();
    t_manual();
    t_display();
    t_refuse();
    conclude();
  end
endmodule // tb
`default_nettype wire
